// [sfcf_map.vh]
`ifndef SFCF_MAP_VH
`define SFCF_MAP_VH
// ****************************************
// opcodes
// ****************************************
`define SFCF_OP_ARRAY_READ    8'h03
`define SFCF_OP_FAST_READ     8'h0B
`define SFCF_OP_BLOCK_ERASE   8'h50
`define SFCF_OP_PAGE_TO_BUF   8'h53
`define SFCF_OP_REWRITE       8'h58
`define SFCF_OP_COMPARE       8'h60
`define SFCF_OP_SEC_READ      8'h77
`define SFCF_OP_SECTOR_ERASE  8'h7C
`define SFCF_OP_PAGE_ERASE    8'h81
`define SFCF_OP_PROG_NOERASE  8'h82
`define SFCF_OP_BUF_PROG      8'h83
`define SFCF_OP_BUF_WRITE     8'h84
`define SFCF_OP_PROG_NOERASE2 8'h88
`define SFCF_OP_ID_READ       8'h9F
`define SFCF_OP_DEEP_PD       8'hB9
`define SFCF_OP_RESUME        8'hAB
`define SFCF_OP_BUF_READ_LO   8'hD1
`define SFCF_OP_PAGE_READ     8'hD2
`define SFCF_OP_BUF_READ_HI   8'hD4
`define SFCF_OP_STATUS        8'hD7
`define SFCF_OP_CONT_READ     8'hE8
// ****************************************
// address field layout in the 24 bit address
// ****************************************
`define SFCF_PAGE_MSB         18
`define SFCF_PAGE_LSB         9
`define SFCF_BYTE_MSB         8
`define SFCF_BLOCK_LSB        13
`define SFCF_ADDR_BYTES       3
`define SFCF_DUMMY_ONE        3'h1
`define SFCF_DUMMY_FOUR       3'h4
// ****************************************
// power-up timing
// ****************************************
`define SFCF_CLK_MHZ          50
`define SFCF_PUW_MS           20
`define SFCF_PUW_CYC          (`SFCF_PUW_MS * 1000 * `SFCF_CLK_MHZ)
`endif

// [sfcf_buf2.v]
`timescale 1ns/1ps
`default_nettype none
// two-entry buffer, receiver stall loses no word
module sfcf_buf2 #(
  parameter W = 8
) (
  // clock
  input  wire         clk_sys_in,
  input  wire         srst_in,
  input  wire         ce_in,
  input  wire         flush_in,
  // fill side
  input  wire         in_valid_in,
  output wire         in_ready_out,
  input  wire [W-1:0] in_data_in,
  // drain side
  output wire         out_valid_out,
  input  wire         out_ready_in,
  output wire [W-1:0] out_data_out
);
  reg [W-1:0] mem_r [0:1]; // storage
  reg         wp_r;        // write index
  reg         rp_r;        // read index
  reg [1:0]   cnt_r;       // fill level
  wire        push;
  wire        pop;
  assign in_ready_out  = (cnt_r != 2'h2);
  assign out_valid_out = (cnt_r != 2'h0);
  assign out_data_out  = mem_r[rp_r];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;
  // pointers and level
  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end else if (ce_in) begin
      if (flush_in) begin
        wp_r  <= 1'b0;
        rp_r  <= 1'b0;
        cnt_r <= 2'h0;
      end else begin
        if (push) wp_r <= ~wp_r;
        if (pop) rp_r <= ~rp_r;
        if (push & ~pop) cnt_r <= cnt_r + 2'h1;
        else if (pop & ~push) cnt_r <= cnt_r - 2'h1;
      end
    end
  end
  // data store, no reset needed
  always @(posedge clk_sys_in) begin
    if (ce_in & push & ~flush_in) mem_r[wp_r] <= in_data_in;
  end
endmodule
`default_nettype wire

// [sfcf_frame.v]
`timescale 1ns/1ps
`default_nettype none
`include "sfcf_map.vh"
module sfcf_frame #(
  parameter [31:0] PUW_CYC = `SFCF_PUW_CYC
) (
  // clock and reset
  input  wire        clk_sys_in,
  input  wire        srst_in,
  input  wire        ce_in,
  input  wire        por_active_in,
  // serial pins
  input  wire        cs_n_in,
  input  wire        sck_in,
  input  wire        si_in,
  output wire        so_out,
  output wire        so_oe_n_out,
  // outgoing read data, to shift onto so
  input  wire        rd_valid_in,
  output wire        rd_ready_out,
  input  wire [7:0]  rd_data_in,
  // decoded command
  output reg         cmd_valid_out,
  output reg  [7:0]  cmd_op_out,
  output reg  [9:0]  cmd_page_out,
  output reg  [8:0]  cmd_byte_out,
  output reg         cmd_write_ok_out,
  // write data bytes from host
  output reg         wr_valid_out,
  output reg  [7:0]  wr_data_out,
  // state
  output reg         mode3_out,
  output reg         standby_out
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  reg [1:0] cs_s_r;  // select sync
  reg [1:0] sck_s_r; // clock sync
  reg [1:0] si_s_r;  // data sync
  reg       cs_d_r;  // previous select
  reg       sck_d_r; // previous clock
  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      cs_s_r  <= 2'h0; // reset as selected: a low held through reset gives no fall
      sck_s_r <= 2'h3;
      si_s_r  <= 2'h0;
      cs_d_r  <= 1'b0; // no fall until a real high has been seen
      sck_d_r <= 1'b1;
    end else if (ce_in) begin
      cs_s_r  <= {cs_s_r[0], cs_n_in};
      sck_s_r <= {sck_s_r[0], sck_in};
      si_s_r  <= {si_s_r[0], si_in};
      cs_d_r  <= cs_s_r[1];
      sck_d_r <= sck_s_r[1];
    end
  end
  wire cs_fall = cs_d_r & ~cs_s_r[1];
  wire sck_rise = ~sck_d_r & sck_s_r[1];
  wire sck_fall = sck_d_r & ~sck_s_r[1];
  wire sel = ~cs_s_r[1];
  // ****************************************
  // framing state
  // ****************************************
  localparam ST_IDLE = 2'h0; // waiting for select fall
  localparam ST_OP   = 2'h1; // opcode byte
  localparam ST_ADDR = 2'h2; // address bytes
  localparam ST_DATA = 2'h3; // dummy then data
  reg [1:0]  st_r, st_nxt;
  reg [2:0]  bit_r;     // bit within byte
  reg [7:0]  sh_r;      // input shifter
  reg [23:0] addr_r;    // collected address
  reg [1:0]  acnt_r;    // address bytes seen
  reg [2:0]  dummy_r;   // dummy bytes left
  reg        armed_r;   // select was seen high since reset or por
  reg [31:0] puw_r;     // power-up write counter
  reg        puw_done_r;
  reg [7:0]  osh_r;     // output shifter
  reg [2:0]  obit_r;    // output bits left
  reg        oen_r;     // driving so
  wire [7:0] byte_in = {sh_r[6:0], si_s_r[1]}; // msb first
  wire       byte_done = sck_rise & (bit_r == 3'h7);
  // opcode classes
  function has_addr;
    input [7:0] op;
    begin
      case (op)
        `SFCF_OP_ID_READ, `SFCF_OP_DEEP_PD,
        `SFCF_OP_RESUME, `SFCF_OP_STATUS: has_addr = 1'b0;
        default: has_addr = 1'b1;
      endcase
    end
  endfunction
  function [2:0] dummies;
    input [7:0] op;
    begin
      case (op)
        `SFCF_OP_FAST_READ, `SFCF_OP_BUF_READ_HI: dummies = `SFCF_DUMMY_ONE;
        `SFCF_OP_PAGE_READ, `SFCF_OP_CONT_READ: dummies = `SFCF_DUMMY_FOUR;
        default: dummies = 3'h0;
      endcase
    end
  endfunction
  function is_write;
    input [7:0] op;
    begin
      case (op)
        `SFCF_OP_BLOCK_ERASE, `SFCF_OP_REWRITE, `SFCF_OP_SECTOR_ERASE,
        `SFCF_OP_PAGE_ERASE, `SFCF_OP_PROG_NOERASE, `SFCF_OP_BUF_PROG,
        `SFCF_OP_PROG_NOERASE2: is_write = 1'b1;
        default: is_write = 1'b0;
      endcase
    end
  endfunction
  // next state
  always @* begin
    st_nxt = st_r;
    if (!sel | por_active_in) st_nxt = ST_IDLE;
    else case (st_r)
      ST_IDLE: if (cs_fall & armed_r) st_nxt = ST_OP;
      ST_OP: if (byte_done) st_nxt = has_addr(byte_in) ? ST_ADDR : ST_DATA;
      ST_ADDR: if (byte_done & (acnt_r == 2'h2)) st_nxt = ST_DATA;
      ST_DATA: st_nxt = ST_DATA;
      default: st_nxt = ST_IDLE;
    endcase
  end
  // shifting and decode
  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      st_r <= ST_IDLE;
      bit_r <= 3'h0;
      sh_r <= 8'h00;
      addr_r <= 24'h00_0000;
      acnt_r <= 2'h0;
      dummy_r <= 3'h0;
      armed_r <= 1'b0;
      mode3_out <= 1'b1;
      standby_out <= 1'b0;
      cmd_valid_out <= 1'b0;
      cmd_op_out <= 8'h00;
      cmd_page_out <= 10'h000;
      cmd_byte_out <= 9'h000;
      cmd_write_ok_out <= 1'b0;
      wr_valid_out <= 1'b0;
      wr_data_out <= 8'h00;
    end else if (ce_in) begin
      st_r <= st_nxt;
      cmd_valid_out <= 1'b0;
      wr_valid_out <= 1'b0;
      standby_out <= ~por_active_in & ~sel;
      // select must go high first after reset, so a low held through reset is no start
      if (por_active_in) armed_r <= 1'b0;
      else if (!sel) armed_r <= 1'b1;
      if (cs_fall & ~por_active_in) mode3_out <= sck_s_r[1];
      if (st_nxt == ST_OP && st_r == ST_IDLE) begin
        bit_r <= 3'h0;
        acnt_r <= 2'h0;
      end else if (sck_rise && st_r != ST_IDLE) begin
        sh_r <= byte_in;
        bit_r <= bit_r + 3'h1;
      end
      if (byte_done) begin
        case (st_r)
          ST_OP: begin
            cmd_op_out <= byte_in;
            dummy_r <= dummies(byte_in);
            addr_r <= 24'h00_0000;
            if (!has_addr(byte_in)) begin
              cmd_page_out <= 10'h000;
              cmd_byte_out <= 9'h000;
              cmd_write_ok_out <= 1'b0;
              cmd_valid_out <= 1'b1;
            end
          end
          ST_ADDR: begin
            acnt_r <= acnt_r + 2'h1;
            addr_r <= {addr_r[15:0], byte_in};
            if (acnt_r == 2'h2) begin
              cmd_valid_out <= 1'b1;
              cmd_write_ok_out <= is_write(cmd_op_out) & puw_done_r;
              // reserved bits never reach the outputs
              case (cmd_op_out)
                `SFCF_OP_BLOCK_ERASE: begin
                  cmd_page_out <= {addr_r[10:5], 4'h0};
                  cmd_byte_out <= 9'h000;
                end
                `SFCF_OP_SECTOR_ERASE: begin
                  cmd_page_out <= {addr_r[10], 9'h000};
                  cmd_byte_out <= 9'h000;
                end
                `SFCF_OP_PAGE_TO_BUF, `SFCF_OP_REWRITE, `SFCF_OP_COMPARE,
                `SFCF_OP_PAGE_ERASE, `SFCF_OP_BUF_PROG, `SFCF_OP_PROG_NOERASE2: begin
                  cmd_page_out <= addr_r[10:1];
                  cmd_byte_out <= 9'h000;
                end
                `SFCF_OP_BUF_WRITE, `SFCF_OP_BUF_READ_LO, `SFCF_OP_BUF_READ_HI: begin
                  cmd_page_out <= 10'h000;
                  cmd_byte_out <= {addr_r[0], byte_in};
                end
                `SFCF_OP_SEC_READ: begin
                  cmd_page_out <= 10'h000;
                  cmd_byte_out <= 9'h000;
                end
                default: begin
                  cmd_page_out <= addr_r[10:1];
                  cmd_byte_out <= {addr_r[0], byte_in};
                end
              endcase
            end
          end
          ST_DATA: begin
            if (dummy_r != 3'h0) dummy_r <= dummy_r - 3'h1;
            else begin
              wr_valid_out <= 1'b1;
              wr_data_out <= byte_in;
            end
          end
          default: ;
        endcase
      end
    end
  end
  // power-up write delay, counted from release of power-on reset or of sync reset
  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      puw_r <= 32'h0000_0000;
      puw_done_r <= 1'b0;
    end else if (ce_in) begin
      if (por_active_in) begin
        puw_r <= 32'h0000_0000;
        puw_done_r <= 1'b0;
      end else if (puw_r >= PUW_CYC - 32'h0000_0001) puw_done_r <= 1'b1;
      else puw_r <= puw_r + 32'h0000_0001;
    end
  end
  // ****************************************
  // output path through two-entry buffer
  // ****************************************
  wire       fb_valid;
  wire [7:0] fb_data;
  wire       out_phase = (st_r == ST_DATA) & (dummy_r == 3'h0);
  wire       load = out_phase & (obit_r == 3'h0) & sck_fall;
  sfcf_buf2 #(.W(8)) u_buf (
    .clk_sys_in    (clk_sys_in),
    .srst_in       (srst_in),
    .ce_in         (ce_in),
    .flush_in      (~sel),
    .in_valid_in   (rd_valid_in),
    .in_ready_out  (rd_ready_out),
    .in_data_in    (rd_data_in),
    .out_valid_out (fb_valid),
    .out_ready_in  (load),
    .out_data_out  (fb_data)
  );
  // shift on falling clock so host samples on rising
  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      osh_r <= 8'h00;
      obit_r <= 3'h0;
      oen_r <= 1'b0;
    end else if (ce_in) begin
      if (!sel | por_active_in) oen_r <= 1'b0;
      else if (load & fb_valid) begin
        osh_r <= fb_data;
        obit_r <= 3'h7;
        oen_r <= 1'b1;
      end else if (sck_fall & (obit_r != 3'h0)) begin
        osh_r <= {osh_r[6:0], 1'b0};
        obit_r <= obit_r - 3'h1;
      end
    end
  end
  assign so_out = osh_r[7];
  assign so_oe_n_out = ~oen_r;
endmodule
`default_nettype wire

// [sfcf_frame_properties.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// frame checker
// ****************************************
module sfcf_frame_properties #(
  parameter [31:0] PUW_CYC = 32'h0000_0032
) (
  // clock, reset, pins
  input wire logic       clk_sys_in,
  input wire logic       srst_in,
  input wire logic       por_active_in,
  input wire logic       cs_n_in,
  input wire logic       sck_in,
  input wire logic       so_oe_n_out,
  // decoded command and state
  input wire logic       cmd_valid_out,
  input wire logic [7:0] cmd_op_out,
  input wire logic [9:0] cmd_page_out,
  input wire logic [8:0] cmd_byte_out,
  input wire logic       cmd_write_ok_out,
  input wire logic       wr_valid_out,
  input wire logic       mode3_out,
  input wire logic       standby_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  logic [31:0] por_low_r;  // cycles since power-on reset left, saturating
  // count only por, so a sync reset cannot reopen the write window early
  always @(posedge clk_sys_in) begin
    if (por_active_in) por_low_r <= 32'h0000_0000;
    else if (por_low_r != 32'hffff_ffff) por_low_r <= por_low_r + 32'h0000_0001;
  end
  sequence sel_fall_s; $fell(cs_n_in) && !por_active_in; endsequence
  sequence idle_held_s; ($stable(sck_in) && !cs_n_in)[*5]; endsequence
  chk_reset_state: assert property ($fell(srst_in) |-> so_oe_n_out && mode3_out)
    else $error("reset state wrong");
  chk_por_quiet: assert property (por_active_in[*3] |-> !cmd_valid_out && !wr_valid_out)
    else $error("activity during por");
  chk_write_gate: assert property (cmd_write_ok_out |-> por_low_r > PUW_CYC)
    else $error("write allowed too early");
  chk_cmd_selected: assert property (cmd_valid_out |-> !standby_out && !por_active_in)
    else $error("command while idle");
  chk_standby_idle: assert property ((cs_n_in && !por_active_in)[*6] |-> standby_out)
    else $error("no standby when idle");
  chk_mode_sample: assert property (sel_fall_s ##1 idle_held_s |=> mode3_out == $past(sck_in))
    else $error("clock mode not sampled");
  chk_so_released: assert property (cs_n_in[*6] |-> so_oe_n_out)
    else $error("so driven while deselected");
  chk_erase_fields: assert property (cmd_valid_out && cmd_op_out == 8'h50
    |-> cmd_page_out[3:0] == 4'h0 && cmd_byte_out == 9'h000)
    else $error("block erase fields wrong");
  chk_buffer_fields: assert property (cmd_valid_out && (cmd_op_out == 8'h84 ||
    cmd_op_out == 8'hd1 || cmd_op_out == 8'hd4) |-> cmd_page_out == 10'h000)
    else $error("buffer op page not ignored");
  chk_wr_spacing: assert property (wr_valid_out |=> (!wr_valid_out)[*4])
    else $error("write bytes too close");
endmodule
bind sfcf_frame sfcf_frame_properties #(.PUW_CYC(PUW_CYC)) sfcf_frame_properties_inst (
  .clk_sys_in(clk_sys_in), .srst_in(srst_in), .por_active_in(por_active_in),
  .cs_n_in(cs_n_in), .sck_in(sck_in), .so_oe_n_out(so_oe_n_out),
  .cmd_valid_out(cmd_valid_out), .cmd_op_out(cmd_op_out), .cmd_page_out(cmd_page_out),
  .cmd_byte_out(cmd_byte_out), .cmd_write_ok_out(cmd_write_ok_out),
  .wr_valid_out(wr_valid_out), .mode3_out(mode3_out), .standby_out(standby_out));
`default_nettype wire

// [sfcf_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// host side: select, clock and data in
// ****************************************
module sfcf_host_model (
  // serial pins
  output logic      cs_n_out,
  output logic      sck_out,
  output logic      si_out,
  input  wire logic so_in
);
  logic [7:0] rx_q [0:1];  // the two data bytes seen on so
  initial begin
    cs_n_out = 1'b1;  // deselected from time zero
    sck_out = 1'b1;
    si_out = 1'b0;
  end
  // one byte, 160 ns per bit; so is read late, just before the next fall
  task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck_out = 1'b0;
      si_out = tx[i];
      #80;
      sck_out = 1'b1;
      #80;
      rx[i] = so_in;
    end
  endtask
  // whole frame; the clock stands at its idle level outside it
  task automatic frame(input logic [7:0] op, input logic [23:0] adr, input int nad,
                       input int ndum, input logic [7:0] d0, input logic [7:0] d1,
                       input logic idle);
    logic [7:0] rx;
    sck_out = idle;
    #160;
    cs_n_out = 1'b0;
    #160;
    shift(op, rx);
    for (int i = 0; i < nad; i++) shift(adr[23-8*i -: 8], rx);
    repeat (ndum) shift(~d0, rx);
    shift(d0, rx_q[0]);
    shift(d1, rx_q[1]);
    sck_out = idle;
    #80;
    cs_n_out = 1'b1;
    si_out = ~si_out;  // released line must not keep its last value
    #320;
  endtask
endmodule
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ****************************************
  // design, host and wiring
  // ****************************************
  logic clk_sys_in = 1'b0, srst_in = 1'b1, por_active_in = 1'b1, rd_valid_in = 1'b0;
  logic [7:0] rd_data_in = 8'h00;
  wire logic cs_n, sck, si, so_out, so_oe_n_out, rd_ready_out, cmd_valid_out;
  wire logic cmd_write_ok_out, wr_valid_out, mode3_out, standby_out;
  wire logic [7:0] cmd_op_out, wr_data_out;
  wire logic [9:0] cmd_page_out;
  wire logic [8:0] cmd_byte_out;
  wire logic so_pin = so_oe_n_out ? 1'bz : so_out;  // pin as the host sees it
  int failures = 0, checks_done = 0, cyc = 0, ncmd = 0;
  logic [15:0] seed = 16'h004d;
  logic [7:0] wq [$];
  logic [7:0] rb [0:2];
  logic [7:0] ops [21] = '{8'h03, 8'h0b, 8'h50, 8'h53, 8'h58, 8'h60, 8'h77, 8'h7c, 8'h81,
    8'h82, 8'h83, 8'h84, 8'h88, 8'h9f, 8'hb9, 8'hab, 8'hd1, 8'hd2, 8'hd4, 8'hd7, 8'he8};
  always #10 clk_sys_in = ~clk_sys_in;
  sfcf_frame #(.PUW_CYC(32'h0000_0190)) sfcf_frame_inst (.clk_sys_in(clk_sys_in),
    .srst_in(srst_in), .ce_in(1'b1), .por_active_in(por_active_in), .cs_n_in(cs_n),
    .sck_in(sck), .si_in(si), .so_out(so_out), .so_oe_n_out(so_oe_n_out),
    .rd_valid_in(rd_valid_in), .rd_ready_out(rd_ready_out), .rd_data_in(rd_data_in),
    .cmd_valid_out(cmd_valid_out), .cmd_op_out(cmd_op_out), .cmd_page_out(cmd_page_out),
    .cmd_byte_out(cmd_byte_out), .cmd_write_ok_out(cmd_write_ok_out),
    .wr_valid_out(wr_valid_out), .wr_data_out(wr_data_out), .mode3_out(mode3_out),
    .standby_out(standby_out));
  sfcf_host_model sfcf_host_model_inst (.cs_n_out(cs_n), .sck_out(sck), .si_out(si),
    .so_in(so_pin));
  // ****************************************
  // helpers
  // ****************************************
  // collect write bytes; cut a hang short
  always @(negedge clk_sys_in) begin
    cyc++;
    if (wr_valid_out === 1'b1) wq.push_back(wr_data_out);
    if (cmd_valid_out === 1'b1) ncmd++;
    if (cyc == 40000) begin
      failures++;
      results();
    end
  end
  task results;
    $display("failures %0d checks %0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic int nad(input logic [7:0] op);
    return (op inside {8'h9f, 8'hb9, 8'hab, 8'hd7}) ? 0 : 3;
  endfunction
  function automatic int ndum(input logic [7:0] op);
    return (op inside {8'h0b, 8'hd4}) ? 1 : (op inside {8'hd2, 8'he8}) ? 4 : 0;
  endfunction
  // expected {page, byte} after don't-care bits are dropped
  function automatic logic [18:0] exp_f(input logic [7:0] op, input logic [23:0] a);
    case (op)
      8'h50: return {a[18:13], 13'h0000};
      8'h7c: return {a[18], 18'h0_0000};
      8'h77: return 19'h0_0000;
      8'h84, 8'hd1, 8'hd4: return {10'h000, a[8:0]};
      8'h53, 8'h58, 8'h60, 8'h81, 8'h83, 8'h88: return {a[18:9], 9'h000};
      default: return a[18:0];
    endcase
  endfunction
  // offer three read bytes during the dummy byte: two fit, the third is refused
  task automatic fill;
    for (int i = 0; i < 3; i++) begin
      @(negedge clk_sys_in);
      rd_valid_in = 1'b1;
      rd_data_in = rb[i];
      #1 cmp("read room", i < 2, rd_ready_out);
    end
    // hold the refused offer until the first load frees a slot
    while (rd_ready_out !== 1'b1) @(negedge clk_sys_in);
    @(negedge clk_sys_in);
    rd_valid_in = 1'b0;
  endtask
  // one frame with its checks
  task automatic run(input logic [7:0] op, input logic [23:0] a, input logic idle,
                     input logic wok);
    logic [7:0] d0;
    int k;
    d0 = a[7:0] ^ 8'h5a;
    wq.delete();
    fork
      sfcf_host_model_inst.frame(op, a, nad(op), ndum(op), d0, a[15:8], idle);
      begin
        k = 0;
        while (cmd_valid_out !== 1'b1 && k < 3000) begin
          @(negedge clk_sys_in);
          k++;
        end
        cmp("cmd op", op, cmd_op_out);
        if (nad(op) != 0) cmp("fields", exp_f(op, a), {cmd_page_out, cmd_byte_out});
        cmp("write ok", wok && (op inside {8'h50, 8'h58, 8'h7c, 8'h81, 8'h82, 8'h83,
          8'h88}), cmd_write_ok_out);
        if (op == 8'h0b) fill();
      end
    join
    cmp("wr count", 2, wq.size());
    cmp("wr bytes", {d0, a[15:8]}, {wq[0], wq[1]});
    if (op == 8'h0b) cmp("so bytes", {rb[0], rb[1]},
      {sfcf_host_model_inst.rx_q[0], sfcf_host_model_inst.rx_q[1]});
    cmp("mode", idle, mode3_out);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge clk_sys_in);
    @(negedge clk_sys_in) srst_in = 1'b0;
    repeat (4) @(negedge clk_sys_in);
    cmp("so released", 1, so_oe_n_out);
    cmp("mode after reset", 1, mode3_out);
    sfcf_host_model_inst.frame(8'h03, 24'h00_0000, 3, 0, 8'h11, 8'h22, 1'b1);
    cmp("por ignored", 0, ncmd + wq.size());
    @(negedge clk_sys_in) por_active_in = 1'b0;
    repeat (50) @(negedge clk_sys_in);
    cmp("standby", 1, standby_out);
    run(8'h83, 24'h07_fe01, 1'b1, 1'b0);
    run(8'h03, 24'hff_ffff, 1'b0, 1'b0);
    // reset again while the clock mode reads zero: it must return to three
    @(negedge clk_sys_in) srst_in = 1'b1;
    @(negedge clk_sys_in) srst_in = 1'b0;
    @(negedge clk_sys_in);
    cmp("mode after reset", 1, mode3_out);
    for (int i = 0; i < 23; i++) begin
      seed = lfsr(seed);
      rb = '{seed[7:0], seed[15:8], ~seed[7:0]};
      run(ops[i % 21], {seed[7:0], seed}, 1'b1, 1'b1);
    end
    results();
  end
endmodule
`default_nettype wire
